// [pkg/cae_pkg.sv]
package cae_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 16;
  localparam int OFF_W = 12;
  localparam int WORD_K_W = 6;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [2:0] CNT_RST = 3'h0;
  // status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  // cycle counts
  localparam logic [2:0] CYC_ALU = 3'h1;
  localparam logic [2:0] CYC_WORD = 3'h2;
  localparam logic [2:0] CYC_IND_JUMP = 3'h2;
  localparam logic [2:0] CYC_REL_CALL = 3'h3;
  localparam logic [2:0] CYC_IND_CALL = 3'h3;
  localparam logic [2:0] CYC_DIR_CALL = 3'h4;
  localparam logic [2:0] CYC_SKIP_NONE = 3'h1;
  localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
  localparam logic [2:0] CYC_SKIP_TWO = 3'h3;
  localparam logic [2:0] CYC_BR_NOT = 3'h1;
  localparam logic [2:0] CYC_BR_TAKEN = 3'h2;
  // program counter steps
  localparam logic [1:0] PC_STEP_ONE = 2'h1;
  localparam logic [1:0] PC_STEP_TWO = 2'h2;
  localparam logic [1:0] PC_STEP_THREE = 2'h3;

  typedef enum logic [4:0] {
    OP_NONE, OP_ADD_REG, OP_ADD_CARRY, OP_ADD_IMMEDIATE_WORD, OP_SUB_REG,
    OP_SUBTRACT_IMMEDIATE, OP_SUBTRACT_WITH_CARRY, OP_SUBTRACT_CARRY_IMMEDIATE,
    OP_SUBTRACT_IMMEDIATE_WORD, OP_AND_REG, OP_AND_IMMEDIATE, OP_OR_REG, OP_OR_IMMEDIATE,
    OP_EXCLUSIVE_OR, OP_SET_BITS, OP_CLEAR_BITS, OP_TEST_VALUE, OP_INDIRECT_JUMP,
    OP_RELATIVE_CALL, OP_INDIRECT_CALL, OP_DIRECT_CALL, OP_COMPARE_SKIP_EQUAL,
    OP_COMPARE_IMMEDIATE, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR,
    OP_SKIP_IO_BIT_SET, OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR
  } cae_op_t;

  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RUN = 2'b01} cae_state_t;

  // cycles an operation takes, given its condition and the size of the skipped word
  function automatic logic [2:0] cae_cycles(input cae_op_t op, input logic cond, input logic two_word);
    logic [2:0] c;
    c = CYC_ALU;
    case (op)
      OP_ADD_IMMEDIATE_WORD, OP_SUBTRACT_IMMEDIATE_WORD: c = CYC_WORD;
      OP_INDIRECT_JUMP: c = CYC_IND_JUMP;
      OP_RELATIVE_CALL: c = CYC_REL_CALL;
      OP_INDIRECT_CALL: c = CYC_IND_CALL;
      OP_DIRECT_CALL: c = CYC_DIR_CALL;
      OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
      OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET: c = !cond ? CYC_SKIP_NONE : (two_word ? CYC_SKIP_TWO : CYC_SKIP_ONE);
      OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR: c = cond ? CYC_BR_TAKEN : CYC_BR_NOT;
      default: c = CYC_ALU;
    endcase
    return c;
  endfunction
endpackage

// [rtl/cae_core.sv]
// Operation
// RULE1: add register, optional carry, one cycle
// RULE2: word add immediate, two cycles
// RULE3: word subtract immediate, two cycles
// RULE4: subtract register or constant, one cycle
// RULE5: subtract operand and carry, one cycle
// RULE6: logic ops keep carry, one cycle
// RULE7: set/clear bits via or/and-not
// RULE8: test ands register with itself
// RULE9: indirect jump from pointer, two cycles
// RULE10: relative call saves return, three cycles
// RULE11: indirect call saves return, three cycles
// RULE12: direct call absolute target, four cycles
// RULE13: equal compare skips next instruction
// RULE14: compare immediate sets flags, no store
// RULE15: register bit clear/set skip
// RULE16: io bit clear/set skip
// RULE17: flag branch adds offset plus one
// RULE18: skip 1/2/3 cycles, branch taken +1
`timescale 1ns/1ps
module cae_core #(
  parameter int PC_W = cae_pkg::PC_W,
  parameter int OFF_W = cae_pkg::OFF_W
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic issue_i,
  input wire cae_pkg::cae_op_t op_i,
  input wire logic [7:0] rd_val_i,
  input wire logic [7:0] rd_hi_i,
  input wire logic [7:0] source_register_i,
  input wire logic [7:0] imm_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [7:0] io_val_i,
  input wire logic [OFF_W-1:0] offset_i,
  input wire logic [PC_W-1:0] target_i,
  input wire logic [PC_W-1:0] zptr_i,
  input wire logic next_two_word_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] res_lo_o,
  output logic [7:0] res_hi_o,
  output logic wr_lo_o,
  output logic wr_hi_o,
  output logic [7:0] status_flags_register_o,
  output logic [PC_W-1:0] pc_o,
  output logic push_o,
  output logic [PC_W-1:0] ret_addr_o
);
  import cae_pkg::*;

  cae_state_t st_q;
  logic [2:0] cnt_q;
  logic [7:0] p_lo_q, p_hi_q, p_flags_q;
  logic p_wlo_q, p_whi_q, p_push_q;
  logic [PC_W-1:0] p_pc_q, p_ret_q;

  // operand selection
  wire use_imm = op_i == OP_SUBTRACT_IMMEDIATE || op_i == OP_SUBTRACT_CARRY_IMMEDIATE ||
                 op_i == OP_AND_IMMEDIATE || op_i == OP_OR_IMMEDIATE || op_i == OP_SET_BITS ||
                 op_i == OP_CLEAR_BITS || op_i == OP_COMPARE_IMMEDIATE;
  wire use_cin = op_i == OP_ADD_CARRY || op_i == OP_SUBTRACT_WITH_CARRY ||
                 op_i == OP_SUBTRACT_CARRY_IMMEDIATE;
  wire [7:0] a = rd_val_i;
  wire [7:0] b = use_imm ? imm_i : source_register_i;
  wire cin = use_cin & status_flags_register_o[FLAG_C];
  wire [8:0] add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  wire [8:0] sub9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
  wire [15:0] wv = {rd_hi_i, rd_val_i};
  wire [15:0] kw = {10'h000, imm_i[WORD_K_W-1:0]};
  wire [16:0] wadd = {1'b0, wv} + {1'b0, kw};
  wire [16:0] wsub = {1'b0, wv} - {1'b0, kw};
  wire [15:0] word_diff = wsub[15:0];

  // condition sources
  wire bit_reg = source_register_i[bit_sel_i];
  wire bit_io = io_val_i[bit_sel_i];
  wire bit_flag = status_flags_register_o[bit_sel_i];
  wire [PC_W-1:0] off_x = {{(PC_W-OFF_W){offset_i[OFF_W-1]}}, offset_i};
  wire [PC_W-1:0] pc_1 = pc_o + PC_W'(PC_STEP_ONE);
  wire [PC_W-1:0] pc_2 = pc_o + PC_W'(PC_STEP_TWO);
  wire [PC_W-1:0] pc_3 = pc_o + PC_W'(PC_STEP_THREE);
  wire [PC_W-1:0] pc_rel = pc_1 + off_x;
  wire [PC_W-1:0] pc_skip = next_two_word_i ? pc_3 : pc_2;

  logic cond;
  logic [7:0] c_lo, c_hi, c_flags;
  logic c_wlo, c_whi, c_push;
  logic [PC_W-1:0] c_pc, c_ret;

  always_comb begin
    cond = 1'b0;
    c_lo = res_lo_o;
    c_hi = res_hi_o;
    c_flags = status_flags_register_o;
    c_wlo = 1'b0;
    c_whi = 1'b0;
    c_push = 1'b0;
    c_pc = pc_1;
    c_ret = pc_1;
    case (op_i)
      // RULE1: add with carry
      OP_ADD_REG, OP_ADD_CARRY: begin
        c_lo = add9[7:0];
        c_wlo = 1'b1;
        c_flags[FLAG_C] = add9[8];
        c_flags[FLAG_Z] = add9[7:0] == 8'h00;
        c_flags[FLAG_N] = add9[7];
        c_flags[FLAG_V] = (a[7] & b[7] & ~add9[7]) | (~a[7] & ~b[7] & add9[7]);
        c_flags[FLAG_H] = (a[3] & b[3]) | (b[3] & ~add9[3]) | (~add9[3] & a[3]);
      end
      // RULE4: subtract and store
      // RULE5: carry subtract keeps zero chain
      // RULE14: compare without store
      OP_SUB_REG, OP_SUBTRACT_IMMEDIATE, OP_SUBTRACT_WITH_CARRY, OP_SUBTRACT_CARRY_IMMEDIATE,
      OP_COMPARE_IMMEDIATE: begin
        c_lo = (op_i == OP_COMPARE_IMMEDIATE) ? res_lo_o : sub9[7:0];
        c_wlo = op_i != OP_COMPARE_IMMEDIATE;
        c_flags[FLAG_C] = sub9[8];
        c_flags[FLAG_Z] = (sub9[7:0] == 8'h00) & (~use_cin | status_flags_register_o[FLAG_Z]);
        c_flags[FLAG_N] = sub9[7];
        c_flags[FLAG_V] = (a[7] & ~b[7] & ~sub9[7]) | (~a[7] & b[7] & sub9[7]);
        c_flags[FLAG_H] = (~a[3] & b[3]) | (b[3] & sub9[3]) | (sub9[3] & ~a[3]);
      end
      // RULE2: word add
      OP_ADD_IMMEDIATE_WORD: begin
        c_lo = wadd[7:0];
        c_hi = wadd[15:8];
        c_wlo = 1'b1;
        c_whi = 1'b1;
        c_flags[FLAG_C] = wadd[16];
        c_flags[FLAG_Z] = wadd[15:0] == 16'h0000;
        c_flags[FLAG_N] = wadd[15];
        c_flags[FLAG_V] = ~rd_hi_i[7] & wadd[15];
        c_flags[FLAG_S] = wadd[15] ^ (~rd_hi_i[7] & wadd[15]);
      end
      // RULE3: word subtract
      OP_SUBTRACT_IMMEDIATE_WORD: begin
        c_lo = wsub[7:0];
        c_hi = wsub[15:8];
        c_wlo = 1'b1;
        c_whi = 1'b1;
        c_flags[FLAG_C] = wsub[16];
        c_flags[FLAG_Z] = wsub[15:0] == 16'h0000;
        c_flags[FLAG_N] = wsub[15];
        c_flags[FLAG_V] = rd_hi_i[7] & ~wsub[15];
        c_flags[FLAG_S] = wsub[15] ^ (rd_hi_i[7] & ~wsub[15]);
      end
      // RULE6: logic ops
      // RULE7: set and clear bits
      // RULE8: test value
      OP_AND_REG, OP_AND_IMMEDIATE, OP_OR_REG, OP_OR_IMMEDIATE, OP_EXCLUSIVE_OR,
      OP_SET_BITS, OP_CLEAR_BITS, OP_TEST_VALUE: begin
        if (op_i == OP_AND_REG || op_i == OP_AND_IMMEDIATE) begin
          c_lo = a & b;
        end else if (op_i == OP_CLEAR_BITS) begin
          c_lo = a & (8'hff - b);
        end else if (op_i == OP_EXCLUSIVE_OR) begin
          c_lo = a ^ b;
        end else if (op_i == OP_TEST_VALUE) begin
          c_lo = a & a;
        end else begin
          c_lo = a | b;
        end
        c_wlo = op_i != OP_TEST_VALUE;
        c_flags[FLAG_Z] = c_lo == 8'h00;
        c_flags[FLAG_N] = c_lo[7];
        c_flags[FLAG_V] = 1'b0;
      end
      // RULE9: indirect jump
      OP_INDIRECT_JUMP: c_pc = zptr_i;
      // RULE10: relative call
      OP_RELATIVE_CALL: begin
        c_pc = pc_rel;
        c_push = 1'b1;
      end
      // RULE11: indirect call
      OP_INDIRECT_CALL: begin
        c_pc = zptr_i;
        c_push = 1'b1;
      end
      // RULE12: direct call
      OP_DIRECT_CALL: begin
        c_pc = target_i;
        c_push = 1'b1;
        c_ret = pc_2;
      end
      // RULE13: equal compare skip
      OP_COMPARE_SKIP_EQUAL: begin
        cond = a == source_register_i;
        c_pc = cond ? pc_skip : pc_1;
      end
      // RULE15: register bit skip
      OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET: begin
        cond = (op_i == OP_SKIP_REG_BIT_SET) ? bit_reg : ~bit_reg;
        c_pc = cond ? pc_skip : pc_1;
      end
      // RULE16: io bit skip
      OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET: begin
        cond = (op_i == OP_SKIP_IO_BIT_SET) ? bit_io : ~bit_io;
        c_pc = cond ? pc_skip : pc_1;
      end
      // RULE17: flag branch
      OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR: begin
        cond = (op_i == OP_BRANCH_FLAG_SET) ? bit_flag : ~bit_flag;
        c_pc = cond ? pc_rel : pc_1;
      end
      default: c_pc = pc_1;
    endcase
  end

  // RULE18: cycle count by condition
  wire [2:0] cyc = cae_cycles(op_i, cond, next_two_word_i);
  wire take = issue_i && st_q == ST_IDLE;
  wire take_one = take && cyc == CYC_ALU;
  wire take_multi = take && cyc != CYC_ALU;
  wire fin_multi = st_q == ST_RUN && cnt_q == 3'h1;
  wire commit = take_one | fin_multi;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      cnt_q <= CNT_RST;
      busy_o <= 1'b0;
    end else if (take_multi) begin
      st_q <= ST_RUN;
      cnt_q <= cyc - 3'h1;
      busy_o <= 1'b1;
    end else if (st_q == ST_RUN) begin
      cnt_q <= cnt_q - 3'h1;
      if (fin_multi) begin
        st_q <= ST_IDLE;
        busy_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      p_lo_q <= 8'h00;
      p_hi_q <= 8'h00;
      p_flags_q <= FLAGS_RST;
      p_wlo_q <= 1'b0;
      p_whi_q <= 1'b0;
      p_push_q <= 1'b0;
      p_pc_q <= PC_W'(PC_RST);
      p_ret_q <= PC_W'(PC_RST);
    end else if (take_multi) begin
      p_lo_q <= c_lo;
      p_hi_q <= c_hi;
      p_flags_q <= c_flags;
      p_wlo_q <= c_wlo;
      p_whi_q <= c_whi;
      p_push_q <= c_push;
      p_pc_q <= c_pc;
      p_ret_q <= c_ret;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      wr_lo_o <= 1'b0;
      wr_hi_o <= 1'b0;
      push_o <= 1'b0;
      res_lo_o <= 8'h00;
      res_hi_o <= 8'h00;
      status_flags_register_o <= FLAGS_RST;
      pc_o <= PC_W'(PC_RST);
      ret_addr_o <= PC_W'(PC_RST);
    end else begin
      done_o <= commit;
      wr_lo_o <= commit & (take_one ? c_wlo : p_wlo_q);
      wr_hi_o <= commit & (take_one ? c_whi : p_whi_q);
      push_o <= commit & (take_one ? c_push : p_push_q);
      if (commit) begin
        res_lo_o <= take_one ? c_lo : p_lo_q;
        res_hi_o <= take_one ? c_hi : p_hi_q;
        status_flags_register_o <= take_one ? c_flags : p_flags_q;
        pc_o <= take_one ? c_pc : p_pc_q;
        ret_addr_o <= take_one ? c_ret : p_ret_q;
      end
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_wait1;
    busy_o && !done_o;
  endsequence

  property p_add_sum;
    take && op_i == OP_ADD_REG |=> done_o && wr_lo_o && res_lo_o == 8'($past(rd_val_i) + $past(source_register_i));
  endproperty
  a_add_sum: assert property (p_add_sum) else $error("add result wrong"); // RULE1
  property p_word_add;
    take && op_i == OP_ADD_IMMEDIATE_WORD |=> s_wait1 ##1 done_o && wr_hi_o && wr_lo_o;
  endproperty
  a_word_add: assert property (p_word_add) else $error("word add timing wrong"); // RULE2
  property p_word_sub;
    take && op_i == OP_SUBTRACT_IMMEDIATE_WORD |=> s_wait1 ##1 done_o && {res_hi_o, res_lo_o} == $past(word_diff, 2);
  endproperty
  a_word_sub: assert property (p_word_sub) else $error("word subtract wrong"); // RULE3
  property p_sub_borrow;
    take && op_i == OP_SUBTRACT_IMMEDIATE |=> status_flags_register_o[FLAG_C] == ($past(rd_val_i) < $past(imm_i));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("borrow flag wrong"); // RULE4
  property p_logic_carry;
    take && (op_i == OP_OR_REG || op_i == OP_EXCLUSIVE_OR) |=>
      $stable(status_flags_register_o[FLAG_C]) && !status_flags_register_o[FLAG_V];
  endproperty
  a_logic_carry: assert property (p_logic_carry) else $error("logic op changed carry"); // RULE6
  property p_clear_bits;
    take && op_i == OP_CLEAR_BITS |=> res_lo_o == ($past(rd_val_i) & ~$past(imm_i));
  endproperty
  a_clear_bits: assert property (p_clear_bits) else $error("clear bits wrong"); // RULE7
  property p_test;
    take && op_i == OP_TEST_VALUE |=>
      done_o && !wr_lo_o && status_flags_register_o[FLAG_Z] == ($past(rd_val_i) == 8'h00);
  endproperty
  a_test: assert property (p_test) else $error("test value wrong"); // RULE8
  property p_ind_jump;
    take && op_i == OP_INDIRECT_JUMP |=> s_wait1 ##1 done_o && pc_o == $past(zptr_i, 2);
  endproperty
  a_ind_jump: assert property (p_ind_jump) else $error("indirect jump wrong"); // RULE9
  property p_dir_call;
    take && op_i == OP_DIRECT_CALL |=> s_wait1 [*3] ##1 done_o && push_o && pc_o == $past(target_i, 4);
  endproperty
  a_dir_call: assert property (p_dir_call) else $error("direct call wrong"); // RULE12
  property p_skip_one;
    take && op_i == OP_COMPARE_SKIP_EQUAL && rd_val_i == source_register_i && !next_two_word_i |=>
      s_wait1 ##1 done_o && pc_o == $past(pc_o, 2) + PC_W'(PC_STEP_TWO);
  endproperty
  a_skip_one: assert property (p_skip_one) else $error("skip of one word wrong"); // RULE13
  property p_no_skip;
    take && op_i == OP_SKIP_REG_BIT_SET && !bit_reg |=> done_o && pc_o == $past(pc_o) + PC_W'(PC_STEP_ONE);
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("false skip not one cycle"); // RULE18
  property p_branch;
    take && op_i == OP_BRANCH_FLAG_SET && bit_flag |=> s_wait1 ##1 done_o && pc_o == $past(pc_rel, 2);
  endproperty
  a_branch: assert property (p_branch) else $error("taken branch wrong"); // RULE17
endmodule

// [test/cae_core_tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
  end \
end
module cae_core_tb_top;
  import cae_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic issue_i = 1'b0;
  cae_op_t op_i = OP_NONE;
  logic [7:0] rd_val_i = 8'h00;
  logic [7:0] rd_hi_i = 8'h00;
  logic [7:0] source_register_i = 8'h00;
  logic [7:0] imm_i = 8'h00;
  logic [2:0] bit_sel_i = 3'h0;
  logic [7:0] io_val_i = 8'h00;
  logic [11:0] offset_i = 12'h000;
  logic [15:0] target_i = 16'h0000;
  logic [15:0] zptr_i = 16'h0000;
  logic next_two_word_i = 1'b0;
  logic busy_o, done_o, wr_lo_o, wr_hi_o, push_o;
  logic [7:0] res_lo_o, res_hi_o, status_flags_register_o;
  logic [15:0] pc_o, ret_addr_o;
  int fails = 0;
  int total_checks = 0;
  int ticks = 0;
  int bsy;
  logic [7:0] sr = 8'h00;
  logic [15:0] pc = 16'h0000;

  cae_core i_cae_core (.mclk_i(mclk_i), .rst_i(rst_i), .issue_i(issue_i), .op_i(op_i), .rd_val_i(rd_val_i),
    .rd_hi_i(rd_hi_i), .source_register_i(source_register_i), .imm_i(imm_i), .bit_sel_i(bit_sel_i),
    .io_val_i(io_val_i), .offset_i(offset_i), .target_i(target_i), .zptr_i(zptr_i),
    .next_two_word_i(next_two_word_i), .busy_o(busy_o), .done_o(done_o), .res_lo_o(res_lo_o),
    .res_hi_o(res_hi_o), .wr_lo_o(wr_lo_o), .wr_hi_o(wr_hi_o), .status_flags_register_o(status_flags_register_o),
    .pc_o(pc_o), .push_o(push_o), .ret_addr_o(ret_addr_o));

  always #10 mclk_i = ~mclk_i;

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // hang guard
  always @(posedge mclk_i) begin
    ticks++;
    if (ticks == 4000) begin
      fails++;
      $display("[FAIL] run length expected under 4000 seen 4000");
      summarize();
    end
  end

  // issue one op, count cycles to done and busy cycles seen
  task automatic go(input cae_op_t op, output int cyc);
    @(posedge mclk_i);
    #1;
    op_i = op;
    issue_i = 1'b1;
    @(posedge mclk_i);
    #1;
    issue_i = 1'b0;
    cyc = 1;
    bsy = (busy_o === 1'b1);
    while (done_o !== 1'b1 && cyc < 10) begin
      @(posedge mclk_i);
      #1;
      cyc++;
      bsy += (busy_o === 1'b1);
    end
  endtask

  task automatic fin(input int n, input int cyc);
    `CHK("cycles", n, cyc)
    `CHK("busy cycles", n - 1, bsy)
    `CHK("pc", pc, pc_o)
    `CHK("flags", sr, status_flags_register_o)
  endtask

  function automatic logic [7:0] fa(logic [7:0] o, logic [7:0] r, logic c, logic h, logic v, logic za, logic ar);
    fa = o;
    fa[FLAG_Z] = (r == 8'h00) & (za ? o[FLAG_Z] : 1'b1);
    fa[FLAG_N] = r[7];
    fa[FLAG_V] = v;
    if (ar) begin
      fa[FLAG_C] = c;
      fa[FLAG_H] = h;
    end
  endfunction

  task automatic arith(input cae_op_t op, input logic [7:0] a, input logic [7:0] b, input logic sub,
    input logic cu, input logic wr, input logic im);
    logic ci;
    logic [8:0] s;
    logic h;
    logic v;
    int cyc;
    ci = cu & sr[FLAG_C];
    if (sub) begin
      s = {1'b0, a} - {1'b0, b} - {8'h00, ci};
      h = {1'b0, a[3:0]} < ({1'b0, b[3:0]} + {4'h0, ci});
      v = (a[7] != b[7]) && (s[7] != a[7]);
    end else begin
      s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      h = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci}) > 5'h0f;
      v = (a[7] == b[7]) && (s[7] != a[7]);
    end
    sr = fa(sr, s[7:0], s[8], h, v, cu & sub, 1'b1);
    rd_val_i = a;
    source_register_i = im ? ~b : b;
    imm_i = im ? b : ~b;
    go(op, cyc);
    pc++;
    fin(1, cyc);
    `CHK("write", wr, wr_lo_o)
    if (wr) `CHK("result", s[7:0], res_lo_o)
  endtask

  task automatic t_arith;
    arith(OP_ADD_REG, 8'h7f, 8'h01, 1'b0, 1'b0, 1'b1, 1'b0);
    arith(OP_ADD_REG, 8'hff, 8'h01, 1'b0, 1'b0, 1'b1, 1'b0);
    arith(OP_ADD_CARRY, 8'h10, 8'h2f, 1'b0, 1'b1, 1'b1, 1'b0);
    arith(OP_SUB_REG, 8'h10, 8'h20, 1'b1, 1'b0, 1'b1, 1'b0);
    arith(OP_SUBTRACT_WITH_CARRY, 8'h21, 8'h20, 1'b1, 1'b1, 1'b1, 1'b0);
    arith(OP_COMPARE_IMMEDIATE, 8'h05, 8'h05, 1'b1, 1'b0, 1'b0, 1'b1);
    arith(OP_SUBTRACT_CARRY_IMMEDIATE, 8'h05, 8'h05, 1'b1, 1'b1, 1'b1, 1'b1);
    arith(OP_SUBTRACT_IMMEDIATE, 8'h80, 8'h01, 1'b1, 1'b0, 1'b1, 1'b1);
    arith(OP_COMPARE_IMMEDIATE, 8'h00, 8'h01, 1'b1, 1'b0, 1'b0, 1'b1);
    $display("test arith done");
  endtask

  task automatic t_logic;
    cae_op_t ops [8] = '{OP_AND_REG, OP_AND_IMMEDIATE, OP_OR_REG, OP_OR_IMMEDIATE, OP_EXCLUSIVE_OR,
      OP_SET_BITS, OP_CLEAR_BITS, OP_TEST_VALUE};
    logic [7:0] ex [8] = '{8'h42, 8'h42, 8'hdb, 8'hdb, 8'h99, 8'hdb, 8'h81, 8'hc3};
    logic im [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    int cyc;
    rd_val_i = 8'hc3;
    foreach (ops[i]) begin
      source_register_i = im[i] ? 8'hff : 8'h5a;
      imm_i = im[i] ? 8'h5a : 8'hff;
      sr = fa(sr, ex[i], 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      go(ops[i], cyc);
      pc++;
      fin(1, cyc);
      `CHK("logic write", (i != 7), wr_lo_o)
      if (i != 7) `CHK("logic result", ex[i], res_lo_o)
    end
    $display("test logic done");
  endtask

  task automatic word(input cae_op_t op, input logic [15:0] a, input logic [5:0] k, input logic sub);
    logic [15:0] r;
    int cyc;
    r = sub ? a - {10'h000, k} : a + {10'h000, k};
    sr[FLAG_C] = sub ? (r[15] & !a[15]) : (!r[15] & a[15]);
    sr[FLAG_V] = sub ? (a[15] & !r[15]) : (!a[15] & r[15]);
    sr[FLAG_N] = r[15];
    sr[FLAG_Z] = (r == 16'h0000);
    sr[FLAG_S] = r[15] ^ sr[FLAG_V];
    rd_val_i = a[7:0];
    rd_hi_i = a[15:8];
    imm_i = {2'b11, k};
    go(op, cyc);
    pc++;
    fin(2, cyc);
    `CHK("word result", r, {res_hi_o, res_lo_o})
    `CHK("word writes", 2'b11, {wr_hi_o, wr_lo_o})
  endtask

  task automatic t_word;
    word(OP_ADD_IMMEDIATE_WORD, 16'hffff, 6'h01, 1'b0);
    word(OP_ADD_IMMEDIATE_WORD, 16'h7fc1, 6'h3f, 1'b0);
    word(OP_SUBTRACT_IMMEDIATE_WORD, 16'h0000, 6'h01, 1'b1);
    word(OP_SUBTRACT_IMMEDIATE_WORD, 16'h8000, 6'h3f, 1'b1);
    $display("test word done");
  endtask

  task automatic flow(input cae_op_t op, input int n, input logic [15:0] np, input logic p, input logic [15:0] ra);
    int cyc;
    go(op, cyc);
    pc = np;
    fin(n, cyc);
    `CHK("push", p, push_o)
    if (p) `CHK("return address", ra, ret_addr_o)
  endtask

  task automatic t_flow;
    zptr_i = 16'h1234;
    offset_i = 12'hff0;
    target_i = 16'h2000;
    flow(OP_INDIRECT_JUMP, 2, 16'h1234, 1'b0, 16'h0000);
    flow(OP_RELATIVE_CALL, 3, pc + 16'hfff0 + 16'h0001, 1'b1, pc + 16'h0001);
    zptr_i = 16'h0456;
    flow(OP_INDIRECT_CALL, 3, 16'h0456, 1'b1, pc + 16'h0001);
    flow(OP_DIRECT_CALL, 4, 16'h2000, 1'b1, pc + 16'h0002);
    $display("test flow done");
  endtask

  task automatic t_skip;
    cae_op_t ops [5] = '{OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
      OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET};
    logic [7:0] m;
    logic [7:0] v;
    logic c;
    int cyc;
    int n;
    foreach (ops[i]) for (int j = 0; j < 4; j++) begin
      c = j[0];
      bit_sel_i = 3'(i + 3 * j);
      m = 8'h01 << bit_sel_i;
      v = (ops[i] == OP_SKIP_REG_BIT_SET || ops[i] == OP_SKIP_IO_BIT_SET) ? (c ? m : ~m) : (c ? ~m : m);
      source_register_i = (i > 2) ? ~v : v;
      io_val_i = (i > 2) ? v : ~v;
      if (i == 0) begin
        rd_val_i = 8'h5a;
        source_register_i = c ? 8'h5a : 8'h5b;
      end
      next_two_word_i = j[1];
      n = !c ? 1 : (j[1] ? 3 : 2);
      go(ops[i], cyc);
      pc = pc + 16'(n);
      fin(n, cyc);
    end
    $display("test skip done");
  endtask

  task automatic t_branch;
    cae_op_t op;
    logic c;
    int cyc;
    for (int j = 0; j < 16; j++) begin
      bit_sel_i = 3'(j);
      op = j[3] ? OP_BRANCH_FLAG_CLEAR : OP_BRANCH_FLAG_SET;
      c = sr[j[2:0]] ^ j[3];
      offset_i = j[0] ? 12'h7ff : 12'h800;
      go(op, cyc);
      pc = c ? pc + {{4{offset_i[11]}}, offset_i} + 16'h0001 : pc + 16'h0001;
      fin(c ? 2 : 1, cyc);
    end
    $display("test branch done");
  endtask

  task automatic t_refuse;
    target_i = 16'h0abc;
    @(posedge mclk_i);
    #1;
    op_i = OP_DIRECT_CALL;
    issue_i = 1'b1;
    @(posedge mclk_i);
    #1;
    op_i = OP_ADD_REG;
    repeat (2) @(posedge mclk_i);
    #1;
    issue_i = 1'b0;
    @(posedge mclk_i);
    #1;
    `CHK("call done", 1'b1, done_o)
    `CHK("call pc", 16'h0abc, pc_o)
    @(posedge mclk_i);
    #1;
    `CHK("no extra op", 2'b00, {done_o, wr_lo_o})
    $display("test refuse done");
  endtask

  initial begin
    repeat (12) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    t_arith();
    t_logic();
    t_word();
    t_flow();
    t_skip();
    t_branch();
    t_refuse();
    summarize();
  end
endmodule
